/* rtl/lgram_consts.vh */
// Purpose: Constants for the large dual-port block RAM.
// Assumes: One 250 MHz clock (hclk); port clocks become clock enables.
// Notes: Offsets are AHB-Lite byte addresses.
// Operation
// [R01] Array holds 589,824 bits as 4096 rows of sixteen 9-bit lanes.
// [R02] Modes: true dual-port, simple dual-port, single-port and FIFO.
// [R03] No preload; contents stay undefined until written.
// [R04] Write select, data, address and byte enables are registered first.
// [R05] Each read path has an output register that can be bypassed.
// [R06] Shapes 64Kx9, 32Kx18, 16Kx36, 8Kx72, 4Kx144, with 8-bit variants.
// [R07] The 144-bit shape is refused in true dual-port mode.
// [R08] Simple dual-port mixes 9..72-bit shapes; 144 pairs only with 144.
// [R09] True dual-port lets each port take any 9..72-bit shape.
// [R10] Write select alone chooses write or read; no read enable.
// [R11] A write needs write select and the lane's byte enable.
// [R12] Byte enables exist for x18, x36, x72; x9 has no masking.
// [R13] In 144-bit simple dual-port both enable sets form 16 enables.
// [R14] Enable bit i gates write-data bits 9i to 9i+8.
// [R15] Any pattern of byte enables is accepted in one write.
// [R16] In 8-bit shapes each enable governs one 8-bit lane likewise.
// [R17] Input registers share one clock; output register has its own enable.
// [R18] Each port has its own clock enable, write select and clear.
// [R19] Each port has 72 data inputs and 72 outputs; 144 uses both.
// [R20] Masked-off lanes keep their stored contents.
// [R21] Port A logic follows port A's enable, port B logic port B's.
// [R22] Write side registers write inputs; read side registers read inputs.
// [R23] Registers clear asynchronously, except the read-enable register.
// [R24] User logic avoids same-address collisions; results are undefined.
// [R25] Deasserted clock enable holds the port's registers and blocks writes.
`ifndef LGRAM_CONSTS_VH
`define LGRAM_CONSTS_VH
`define LGRAM_OFS_CTRL 8'h00
`define LGRAM_OFS_STAT 8'h04
`define LGRAM_CTRL_RST 32'h0000_076C
`define LGRAM_F_MODE 1:0
`define LGRAM_F_SHA 4:2
`define LGRAM_F_SHB 7:5
`define LGRAM_F_ORA 8
`define LGRAM_F_ORB 9
`define LGRAM_F_B9 10
`define LGRAM_MODE_TDP 2'h0
`define LGRAM_MODE_SDP 2'h1
`define LGRAM_MODE_SP 2'h2
`define LGRAM_MODE_FIFO 2'h3
`define LGRAM_SH_X9 3'h0
`define LGRAM_SH_X144 3'h4
`define LGRAM_ROWS 4096
`define LGRAM_LANES 16
`define LGRAM_HSIZE_WORD 3'h2
`endif

/* rtl/lgram_port.v */
// Purpose: One RAM port: input registers, lane mapping, read extraction.
// Assumes: Shape and lane packing are static while traffic flows.
// Notes: Array access is one edge after input capture.
`timescale 1ns/1ps
`include "lgram_consts.vh"
module lgram_port (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Port controls
	input wire clr,
	input wire cen,
	input wire ocen,
	input wire we,
	input wire wr_ok,
	input wire [15:0] addr,
	input wire [143:0] din,
	input wire [15:0] be,
	// Configuration
	input wire [2:0] shape,
	input wire byte9,
	input wire outreg,
	// Array side
	output wire [11:0] row,
	output wire [15:0] wmask,
	output wire [143:0] wdata,
	output wire rd_go,
	input wire [143:0] rrow,
	// Read data
	output wire [143:0] dout
);
	reg we_q;
	reg [15:0] addr_q;
	reg [143:0] din_q;
	reg [15:0] be_q;
	reg go_q;
	reg [3:0] roff;
	reg [143:0] dout_q;
	wire [3:0] off;
	wire [15:0] row_w;
	wire [4:0] nl;
	wire wr;
	wire [143:0] dout9;
	wire [127:0] dout8;
	wire [143:0] rd_data;

	// Input capture, held while the clock enable is low
	always @(posedge hclk or negedge hresetn or posedge clr) begin
		if (!hresetn || clr) begin // [R23]
			we_q <= 1'b0;
			addr_q <= 16'h0000;
			din_q <= {9{16'h0000}};
			be_q <= 16'h0000;
		end else if (cen) begin // [R04] [R25] [R17]
			we_q <= we;
			addr_q <= addr;
			din_q <= din;
			be_q <= be;
		end
	end

	// Read-enable register, cleared by reset only
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			go_q <= 1'b0;
		end else begin
			go_q <= cen; // [R23] [R25]
		end
	end

	// Row and first lane of the addressed word
	assign off = addr_q[3:0] << shape;
	assign row_w = addr_q >> (3'd4 - shape);
	assign row = row_w[11:0];
	assign nl = 5'h01 << shape;
	assign wr = go_q & we_q & wr_ok; // [R10] [R11]
	assign rd_go = go_q & ~we_q; // [R10]

	// Lane offset of the last read
	always @(posedge hclk or negedge hresetn or posedge clr) begin
		if (!hresetn || clr) begin
			roff <= 4'h0;
		end else if (rd_go) begin
			roff <= off;
		end
	end

	// Per-lane write mapping and read extraction
	genvar g;
	generate
		for (g = 0; g < `LGRAM_LANES; g = g + 1) begin : lane
			localparam [3:0] GL = g;
			wire [3:0] li = GL - off;
			wire in_w = ({1'b0, li} < nl);
			wire [143:0] sh9 = din_q >> (9 * li);
			wire [143:0] sh8 = din_q >> (8 * li);
			wire [3:0] src = roff + GL;
			wire [143:0] rs = rrow >> (9 * src);
			wire keep = ({1'b0, GL} < nl);
			assign wdata[9*g+8:9*g] = byte9 ? sh9[8:0] : {1'b0, sh8[7:0]}; // [R14] [R16]
			assign wmask[g] = wr & in_w & ((shape == `LGRAM_SH_X9) | be_q[li]); // [R12] [R15] [R20]
			assign dout9[9*g+8:9*g] = keep ? rs[8:0] : 9'h000;
			assign dout8[8*g+7:8*g] = keep ? rs[7:0] : 8'h00; // [R16]
		end
	endgenerate

	assign rd_data = byte9 ? dout9 : {16'h0000, dout8};

	// Output register with its own enable
	always @(posedge hclk or negedge hresetn or posedge clr) begin
		if (!hresetn || clr) begin
			dout_q <= {9{16'h0000}};
		end else if (ocen) begin // [R17]
			dout_q <= rd_data;
		end
	end

	assign dout = outreg ? dout_q : rd_data; // [R05]
endmodule

/* rtl/lgram_top.v */
// Purpose: Large dual-port block RAM with AHB-Lite configuration.
// Assumes: All user ports are synchronous to hclk.
// Notes: Config errors block all writes; status shows them.
`timescale 1ns/1ps
`include "lgram_consts.vh"
module lgram_top (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	// Port A
	input wire clr_a,
	input wire cen_a,
	input wire ocen_a,
	input wire we_a,
	input wire [15:0] addr_a,
	input wire [71:0] din_a,
	input wire [7:0] be_a,
	output wire [71:0] dout_a,
	// Port B
	input wire clr_b,
	input wire cen_b,
	input wire ocen_b,
	input wire we_b,
	input wire [15:0] addr_b,
	input wire [71:0] din_b,
	input wire [7:0] be_b,
	output wire [71:0] dout_b,
	// FIFO status
	output wire fifo_full,
	output wire fifo_empty
);
	reg [31:0] ctrl;
	reg wr_pend;
	reg [16:0] wptr;
	reg [16:0] rptr;
	wire [1:0] mode;
	wire [2:0] sa;
	wire [2:0] sb;
	wire w144a;
	wire w144b;
	wire cfg_err;
	wire is_fifo;
	wire w144;
	wire ap_ok;
	wire [16:0] pmask;
	wire [16:0] dmask;
	wire [16:0] depth;
	wire [16:0] count;
	wire push;
	wire pop;
	wire [16:0] wa17;
	wire [16:0] ra17;
	wire [31:0] stat;
	wire [11:0] row_a;
	wire [11:0] row_b;
	wire [15:0] wm_a;
	wire [15:0] wm_b;
	wire [143:0] wd_a;
	wire [143:0] wd_b;
	wire rg_a;
	wire rg_b;
	wire [143:0] rrow_a;
	wire [143:0] rrow_b;
	wire [143:0] dp_a;
	wire [143:0] dp_b;
	wire [15:0] pa_addr;
	wire [15:0] pb_addr;
	wire pa_we;
	wire pb_we;
	wire pb_cen;
	wire wok_a;
	wire wok_b;

	// Zero-wait slave, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign ap_ok = hsel & hready & htrans[1];

	// Address phase: latch writes, fetch read data
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			hrdata <= 32'h0000_0000;
		end else begin
			wr_pend <= ap_ok & hwrite & (hsize == `LGRAM_HSIZE_WORD) & (haddr[7:0] == `LGRAM_OFS_CTRL);
			if (ap_ok && !hwrite && haddr[7:0] == `LGRAM_OFS_CTRL) begin
				hrdata <= ctrl;
			end else if (ap_ok && !hwrite && haddr[7:0] == `LGRAM_OFS_STAT) begin
				hrdata <= stat;
			end else if (ap_ok && !hwrite) begin
				hrdata <= 32'h0000_0000;
			end
		end
	end

	// Control register, written in the data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= `LGRAM_CTRL_RST;
		end else if (wr_pend) begin
			ctrl <= {21'h00_0000, hwdata[10:0]};
		end
	end

	// Mode and shape decode
	assign mode = ctrl[`LGRAM_F_MODE];
	assign sa = ctrl[`LGRAM_F_SHA];
	assign sb = ctrl[`LGRAM_F_SHB];
	assign w144a = (sa == `LGRAM_SH_X144);
	assign w144b = (sb == `LGRAM_SH_X144);
	assign is_fifo = (mode == `LGRAM_MODE_FIFO);
	assign w144 = (mode == `LGRAM_MODE_SDP) & w144a; // [R13] [R19]

	// Illegal combinations block writes
	assign cfg_err = (sa > `LGRAM_SH_X144) | (sb > `LGRAM_SH_X144)
		| ((mode == `LGRAM_MODE_TDP) & (w144a | w144b)) // [R07] [R09]
		| ((mode == `LGRAM_MODE_SDP) & (w144a != w144b)) // [R08]
		| ((mode == `LGRAM_MODE_SP) & w144a)
		| (is_fifo & ((sa != sb) | w144a)); // [R02]

	// FIFO pointers in words of the chosen shape
	assign pmask = 17'h1_FFFF >> sa;
	assign dmask = pmask >> 1;
	assign depth = dmask + 17'h0_0001;
	assign count = (wptr - rptr) & pmask;
	assign fifo_full = is_fifo & (count == depth);
	assign fifo_empty = is_fifo & (count == 17'h0_0000);
	assign push = is_fifo & ~cfg_err & cen_a & we_a & ~fifo_full;
	assign pop = is_fifo & ~cfg_err & cen_b & we_b & ~fifo_empty;
	assign wa17 = wptr & dmask;
	assign ra17 = rptr & dmask;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wptr <= 17'h0_0000;
			rptr <= 17'h0_0000;
		end else if (!is_fifo) begin
			wptr <= 17'h0_0000;
			rptr <= 17'h0_0000;
		end else begin
			if (push) begin
				wptr <= (wptr + 17'h0_0001) & pmask;
			end
			if (pop) begin
				rptr <= (rptr + 17'h0_0001) & pmask;
			end
		end
	end

	assign stat = {7'h00, count, 5'h00, fifo_full, fifo_empty, cfg_err};

	// Per-mode steering of the two ports
	assign pa_addr = is_fifo ? wa17[15:0] : addr_a;
	assign pa_we = is_fifo ? push : we_a;
	assign pb_addr = is_fifo ? ra17[15:0] : addr_b;
	assign pb_we = (mode == `LGRAM_MODE_TDP) & we_b; // [R10]
	assign pb_cen = (mode == `LGRAM_MODE_SP) ? 1'b0 : (is_fifo ? pop : cen_b); // [R21] [R22]
	assign wok_a = ~cfg_err;
	assign wok_b = ~cfg_err & (mode == `LGRAM_MODE_TDP);

	lgram_port u_pa (
		.hclk(hclk),
		.hresetn(hresetn),
		.clr(clr_a),
		.cen(cen_a),
		.ocen(ocen_a),
		.we(pa_we),
		.wr_ok(wok_a),
		.addr(pa_addr),
		.din(w144 ? {din_b, din_a} : {72'h00_0000_0000_0000_0000, din_a}),
		.be(w144 ? {be_b, be_a} : {8'h00, be_a}),
		.shape(sa),
		.byte9(ctrl[`LGRAM_F_B9]),
		.outreg(ctrl[`LGRAM_F_ORA]),
		.row(row_a),
		.wmask(wm_a),
		.wdata(wd_a),
		.rd_go(rg_a),
		.rrow(rrow_a),
		.dout(dp_a)
	);

	lgram_port u_pb (
		.hclk(hclk),
		.hresetn(hresetn),
		.clr(clr_b), // [R18]
		.cen(pb_cen),
		.ocen(ocen_b),
		.we(pb_we),
		.wr_ok(wok_b),
		.addr(pb_addr),
		.din({72'h00_0000_0000_0000_0000, din_b}),
		.be({8'h00, be_b}),
		.shape(sb),
		.byte9(ctrl[`LGRAM_F_B9]),
		.outreg(ctrl[`LGRAM_F_ORB]),
		.row(row_b),
		.wmask(wm_b),
		.wdata(wd_b),
		.rd_go(rg_b),
		.rrow(rrow_b),
		.dout(dp_b)
	);

	// Storage: sixteen 9-bit lanes of 4096 rows, never initialised
	genvar g;
	generate
		for (g = 0; g < `LGRAM_LANES; g = g + 1) begin : bank
			reg [8:0] ram [0:`LGRAM_ROWS-1]; // [R01] [R03]
			reg [8:0] rda;
			reg [8:0] rdb;
			// Port B lands last on a shared row
			always @(posedge hclk) begin
				if (wm_a[g]) begin // [R20]
					ram[row_a] <= wd_a[9*g+8:9*g];
				end
				if (wm_b[g]) begin // [R24]
					ram[row_b] <= wd_b[9*g+8:9*g];
				end
				if (rg_a) begin
					rda <= ram[row_a];
				end
				if (rg_b) begin
					rdb <= ram[row_b];
				end
			end
			assign rrow_a[9*g+8:9*g] = rda;
			assign rrow_b[9*g+8:9*g] = rdb;
		end
	endgenerate

	// Wide shape returns the upper half on port B
	assign dout_a = dp_a[71:0]; // [R19]
	assign dout_b = w144 ? dp_b[143:72] : dp_b[71:0]; // [R06] [R13]
endmodule

/* dv/lgram_chk.sv */
// Purpose: Port checks for the large dual-port RAM.
// Assumes: One clock hclk, hresetn async active low.
// Notes: Watches top-level ports only.
`timescale 1ns/1ps
module lgram_chk (
	// Clock, reset and bus
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata,
	// RAM ports and flags
	input wire cen_a,
	input wire we_a,
	input wire clr_a,
	input wire [71:0] dout_a,
	input wire cen_b,
	input wire [71:0] dout_b,
	input wire fifo_full,
	input wire fifo_empty
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Idle ports keep their read data
	a_hold_port_a: assert property ((!cen_a && !clr_a && !hsel)[*6] |-> $stable(dout_a))
		else $error("dout_a moved while port A idle");
	a_hold_port_b: assert property ((!cen_b && !hsel)[*6] |-> $stable(dout_b))
		else $error("dout_b moved while port B idle");
	// Bus answers at once and without error
	a_zero_wait: assert property (hreadyout)
		else $error("hreadyout low");
	a_resp_okay: assert property (!hresp)
		else $error("hresp not OKAY");
	a_rdata_hold: assert property (!$past(hsel && htrans[1] && !hwrite) |-> $stable(hrdata))
		else $error("hrdata changed without a read");
	// FIFO flags stay consistent
	a_fifo_excl: assert property (!(fifo_full && fifo_empty))
		else $error("fifo full and empty together");
	a_fill_step: assert property ($past(fifo_empty) |-> !fifo_full)
		else $error("fifo went full from empty");
	a_empty_stays: assert property (fifo_empty && !hsel && !$past(hsel) && !(cen_a && we_a) |=> fifo_empty)
		else $error("fifo left empty without a push");
	// Main scenarios
	c_push: cover property (cen_a && we_a);
	c_read_b: cover property (cen_b);
	c_fifo_used: cover property (!fifo_empty && !fifo_full);
endmodule

bind lgram_top lgram_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cen_a(cen_a),
	.we_a(we_a), .clr_a(clr_a), .dout_a(dout_a), .cen_b(cen_b), .dout_b(dout_b),
	.fifo_full(fifo_full), .fifo_empty(fifo_empty));

/* dv/lgram_fab.sv */
// Purpose: Fabric user logic driving port B.
// Assumes: Port B shares hclk with the bench.
// Notes: Released data shows the inverse of the last value.
`timescale 1ns/1ps
module lgram_fab (
	// Clock
	input wire hclk,
	// Port B drive
	output logic cen_b,
	output logic we_b,
	output logic [15:0] addr_b,
	output logic [71:0] din_b
);
	// Idle port at time zero
	initial begin
		cen_b = 1'h0;
		we_b = 1'h0;
		addr_b = 16'h0;
		din_b = 72'h0;
	end
	// One access, used only while port A is idle
	task acc(input logic w, input logic [15:0] a, input logic [71:0] d);
		@(posedge hclk);
		cen_b <= 1'h1;
		we_b <= w;
		addr_b <= a;
		din_b <= d;
		@(posedge hclk);
		cen_b <= 1'h0;
		din_b <= ~d;
		repeat (2) @(posedge hclk);
		#1;
	endtask
endmodule

/* dv/tb_top.sv */
// Purpose: Self-checking bench for the large dual-port RAM.
// Assumes: Reset shapes are x72 with 9-bit lanes and output registers.
// Notes: Port B is driven by the fabric model.
`timescale 1ns/1ps
module tb_top;
	logic hclk, hresetn, hsel, hwrite, clr_a, cen_a, we_a;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, r;
	logic [15:0] addr_a;
	logic [71:0] din_a;
	logic [7:0] be_a, be_b;
	wire hreadyout, hresp, cen_b, we_b, fifo_full, fifo_empty;
	wire [31:0] hrdata;
	wire [15:0] addr_b;
	wire [71:0] din_b, dout_a, dout_b;
	int fails = 0;
	int samples_checked = 0;
	localparam logic [71:0] w1 = 72'h12_3456_789a_bcde_f012;
	localparam logic [71:0] w2 = 72'hed_cba9_8765_4321_0fed;
	// Block under test and fabric partner
	lgram_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .clr_a(clr_a), .cen_a(cen_a), .ocen_a(1'h1), .we_a(we_a),
		.addr_a(addr_a), .din_a(din_a), .be_a(be_a), .dout_a(dout_a), .clr_b(1'h0), .cen_b(cen_b),
		.ocen_b(1'h1), .we_b(we_b), .addr_b(addr_b), .din_b(din_b), .be_b(be_b), .dout_b(dout_b),
		.fifo_full(fifo_full), .fifo_empty(fifo_empty));
	lgram_fab fab (.hclk(hclk), .cen_b(cen_b), .we_b(we_b), .addr_b(addr_b), .din_b(din_b));
	// Expected word after a lane-masked write
	function automatic logic [71:0] mrg(input logic [71:0] o, n, input logic [7:0] b);
		for (int i = 0; i < 8; i++)
			if (b[i])
				o[9*i+:9] = n[9*i+:9];
		return o;
	endfunction
	task chk(input string n, input logic [71:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s exp %h seen %h", n, exp, seen);
		end
	endtask
	// Single AHB-Lite word transfer
	task ahb(input logic w, input logic [31:0] a, d);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		@(posedge hclk);
		while (hreadyout !== 1'h1) @(posedge hclk);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'h1) @(posedge hclk);
		r = hrdata;
	endtask
	// Port A access, returns once registered data has landed
	task pa(input logic c, w, input logic [15:0] a, input logic [71:0] d, input logic [7:0] b);
		@(posedge hclk);
		cen_a <= c;
		we_a <= w;
		addr_a <= a;
		din_a <= d;
		be_a <= b;
		@(posedge hclk);
		cen_a <= 1'h0;
		din_a <= ~d;
		repeat (2) @(posedge hclk);
		#1;
	endtask
	task print_verdict();
		$display("checks %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		hclk = 1'h0;
		forever #2 hclk = ~hclk;
	end
	// Watchdog
	initial begin
		#20000;
		fails++;
		print_verdict();
	end
	// Test sequence
	initial begin
		{hresetn, hsel, hwrite, clr_a, cen_a, we_a} = 6'h0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		addr_a = 16'h0;
		din_a = 72'h0;
		be_a = 8'hff;
		be_b = 8'hff;
		repeat (20) @(posedge hclk);
		hresetn <= 1'h1;
		ahb(1'h0, 32'h0, 32'h0);
		chk("ctrl", 72'(r), 72'h076c);
		ahb(1'h0, 32'h4, 32'h0);
		chk("status", 72'(r), 72'h0);
		ahb(1'h0, 32'h8, 32'h0);
		chk("unmapped", 72'(r), 72'h0);
		// Masked write over a full word, read on both ports
		pa(1'h1, 1'h1, 16'h5, w1, 8'hff);
		pa(1'h1, 1'h1, 16'h5, w2, 8'h5a);
		pa(1'h1, 1'h0, 16'h5, 72'h0, 8'hff);
		chk("masked a", dout_a, mrg(w1, w2, 8'h5a));
		fab.acc(1'h0, 16'h5, 72'h0);
		chk("masked b", dout_b, mrg(w1, w2, 8'h5a));
		// Port B write seen on A; disabled write dropped
		fab.acc(1'h1, 16'h7, w2);
		pa(1'h0, 1'h1, 16'h5, w2, 8'hff);
		pa(1'h1, 1'h0, 16'h7, 72'h0, 8'hff);
		chk("b to a", dout_a, w2);
		pa(1'h1, 1'h0, 16'h5, 72'h0, 8'hff);
		chk("disabled", dout_a, mrg(w1, w2, 8'h5a));
		// Clear empties the output register; clear acts asynchronously, checked one edge after clr_a rises
		@(posedge hclk);
		clr_a <= 1'h1;
		@(posedge hclk);
		#1;
		chk("clear", dout_a, 72'h0);
		@(posedge hclk);
		clr_a <= 1'h0;
		repeat (8) @(posedge hclk);
		// Widest shape refused in true dual-port
		ahb(1'h1, 32'h0, 32'h0770);
		ahb(1'h0, 32'h4, 32'h0);
		chk("cfg err", 72'(r[0]), 72'h1);
		// One word through the FIFO
		ahb(1'h1, 32'h0, 32'h076f);
		pa(1'h1, 1'h1, 16'h0, w1, 8'hff);
		ahb(1'h0, 32'h4, 32'h0);
		chk("count", 72'(r), 72'h0100);
		chk("full", 72'(fifo_full), 72'h0);
		fab.acc(1'h1, 16'h0, 72'h0);
		chk("pop", dout_b, w1);
		chk("empty", 72'(fifo_empty), 72'h1);
		// Widest shape in simple dual-port: both enable sets form sixteen lanes
		ahb(1'h1, 32'h0, 32'h0591);
		fab.acc(1'h0, 16'h0, w2);
		pa(1'h1, 1'h1, 16'h3, w1, 8'hff);
		// Fabric release leaves the inverse of its last data on din_b
		fab.acc(1'h0, 16'h0, w1);
		@(posedge hclk);
		be_b <= 8'h3c;
		pa(1'h1, 1'h1, 16'h3, w2, 8'h5a);
		@(posedge hclk);
		be_b <= 8'hff;
		pa(1'h1, 1'h0, 16'h3, 72'h0, 8'hff);
		chk("wide low", dout_a, mrg(w1, w2, 8'h5a));
		fab.acc(1'h0, 16'h3, 72'h0);
		chk("wide high", dout_b, mrg(~w2, ~w1, 8'h3c));
		// Eight-bit lanes, port A output register bypassed
		ahb(1'h1, 32'h0, 32'h026c);
		pa(1'h1, 1'h1, 16'h9, w1, 8'hff);
		pa(1'h1, 1'h1, 16'h9, w2, 8'h0f);
		pa(1'h1, 1'h0, 16'h9, 72'h0, 8'hff);
		chk("byte8", dout_a, {8'h00, w1[63:32], w2[31:0]});
		print_verdict();
	end
endmodule
